// ==== crs_regs.vh ====
`ifndef CRS_REGS_VH
`define CRS_REGS_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define CRS_DATA_W 8
`define CRS_PC_W 16

// ----------------------------------------
// Flags register fields
// ----------------------------------------
`define CRS_F_GIE 0
`define CRS_F_ZERO 1
`define CRS_F_CARRY 2
`define CRS_F_SUPER 3
`define CRS_F_XIO 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CRS_F_RST 8'h02
`define CRS_A_RST 8'h00
`define CRS_X_RST 8'h00
`define CRS_SP_RST 8'h00
`define CRS_PC_RST 16'h0000
`define CRS_DM_RST 8'h00

// ----------------------------------------
// Stack pointer operations
// ----------------------------------------
`define CRS_SP_HOLD 3'h0
`define CRS_SP_INC 3'h1
`define CRS_SP_DEC 3'h2
`define CRS_SP_INC2 3'h3
`define CRS_SP_DEC2 3'h4
`define CRS_SP_INC3 3'h5
`define CRS_SP_DEC3 3'h6
`define CRS_SP_LOAD 3'h7

// ----------------------------------------
// Program counter operations
// ----------------------------------------
`define CRS_PC_HOLD 2'h0
`define CRS_PC_INC 2'h1
`define CRS_PC_LOAD 2'h2

// ----------------------------------------
// Flag operation codes
// ----------------------------------------
`define CRS_FOP_NONE 2'h0
`define CRS_FOP_ALU 2'h1
`define CRS_FOP_AND 2'h2
`define CRS_FOP_OR 2'h3

`endif

// ==== crs_flags.v ====
`timescale 1ns/1ps
`include "crs_regs.vh"

module crs_flags (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Flag update from instructions
  input wire [1:0] fop,
  input wire [7:0] fop_mask,
  input wire upd_zero,
  input wire upd_carry,
  input wire zero_in,
  input wire carry_in,
  // Supervisory entry and exit by the CPU itself
  input wire super_enter,
  input wire super_leave,
  // Flags state
  output reg [7:0] flags_q
);

  reg [7:0] flags_d;

  // ----------------------------------------
  // Next flag value
  // ----------------------------------------
  always @* begin
    flags_d = flags_q;
    if (fop == `CRS_FOP_ALU) begin
      if (upd_zero) begin
        flags_d[`CRS_F_ZERO] = zero_in;
      end
      if (upd_carry) begin
        flags_d[`CRS_F_CARRY] = carry_in;
      end
    end else if (fop == `CRS_FOP_AND) begin
      flags_d = flags_q & fop_mask;
    end else if (fop == `CRS_FOP_OR) begin
      flags_d = flags_q | fop_mask;
    end
    // User instructions never alter the supervisory bit
    flags_d[`CRS_F_SUPER] = flags_q[`CRS_F_SUPER];
    if (super_enter) begin
      flags_d[`CRS_F_SUPER] = 1'h1;
    end else if (super_leave) begin
      flags_d[`CRS_F_SUPER] = 1'h0;
    end
    flags_d[7:5] = 3'h0;
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      flags_q <= `CRS_F_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule

// ==== crs_core_regs.v ====
`timescale 1ns/1ps
`include "crs_regs.vh"

module crs_core_regs (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Program counter control
  input wire [1:0] pc_op,
  input wire [15:0] pc_load_val,
  // Accumulator control
  input wire acc_we,
  input wire [7:0] acc_wdata,
  // Index control
  input wire idx_we,
  input wire [7:0] idx_wdata,
  // Stack pointer control
  input wire [2:0] sp_op,
  input wire [7:0] sp_load_val,
  // Data address formation
  input wire [7:0] dm_base,
  input wire dm_indexed,
  // Flag control
  input wire [1:0] fop,
  input wire [7:0] fop_mask,
  input wire upd_zero,
  input wire upd_carry,
  input wire zero_in,
  input wire carry_in,
  input wire super_enter,
  input wire super_leave,
  // Interrupt gating
  input wire irq_pending,
  output wire irq_take,
  // Register state
  output wire [15:0] program_counter_reg,
  output wire [7:0] acc_reg,
  output wire [7:0] index_reg,
  output wire [7:0] stack_pointer_reg,
  output wire [7:0] flags_reg,
  // Memory addresses
  output wire [15:0] pm_addr,
  output reg [7:0] dm_addr_q
);

  reg [15:0] pc_q;
  reg [15:0] pc_d;
  reg [7:0] acc_q;
  reg [7:0] idx_q;
  reg [7:0] sp_q;
  reg [7:0] sp_d;
  reg [7:0] acc_d;
  reg [7:0] idx_d;
  reg [7:0] dm_addr_d;
  wire [7:0] flags_q;

  // ----------------------------------------
  // Stack pointer step decode
  // ----------------------------------------
  // Stack moves wrap modulo 256 inside the data space
  function [7:0] sp_next;
    input [2:0] op;
    input [7:0] sp;
    input [7:0] ld;
    begin
      case (op)
        `CRS_SP_INC: sp_next = sp + 8'h01;
        `CRS_SP_DEC: sp_next = sp - 8'h01;
        `CRS_SP_INC2: sp_next = sp + 8'h02;
        `CRS_SP_DEC2: sp_next = sp - 8'h02;
        `CRS_SP_INC3: sp_next = sp + 8'h03;
        `CRS_SP_DEC3: sp_next = sp - 8'h03;
        `CRS_SP_LOAD: sp_next = ld;
        default: sp_next = sp;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Data address formation
  // ----------------------------------------
  function [7:0] dm_form;
    input [7:0] base;
    input [7:0] offs;
    input indexed;
    begin
      if (indexed) begin
        dm_form = base + offs;
      end else begin
        dm_form = base;
      end
    end
  endfunction

  // ----------------------------------------
  // Program counter
  // ----------------------------------------
  always @* begin
    pc_d = pc_q;
    if (pc_op == `CRS_PC_INC) begin
      pc_d = pc_q + 16'h0001;
    end else if (pc_op == `CRS_PC_LOAD) begin
      pc_d = pc_load_val;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      pc_q <= `CRS_PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  // ----------------------------------------
  // Accumulator
  // ----------------------------------------
  always @* begin
    acc_d = acc_q;
    if (acc_we) begin
      acc_d = acc_wdata;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= `CRS_A_RST;
    end else begin
      acc_q <= acc_d;
    end
  end

  // ----------------------------------------
  // Index
  // ----------------------------------------
  always @* begin
    idx_d = idx_q;
    if (idx_we) begin
      idx_d = idx_wdata;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      idx_q <= `CRS_X_RST;
    end else begin
      idx_q <= idx_d;
    end
  end

  // ----------------------------------------
  // Stack pointer
  // ----------------------------------------
  always @* begin
    sp_d = sp_next(sp_op, sp_q, sp_load_val);
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      sp_q <= `CRS_SP_RST;
    end else begin
      sp_q <= sp_d;
    end
  end

  // ----------------------------------------
  // Data memory address, registered
  // ----------------------------------------
  always @* begin
    dm_addr_d = dm_form(dm_base, idx_q, dm_indexed);
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      dm_addr_q <= `CRS_DM_RST;
    end else begin
      dm_addr_q <= dm_addr_d;
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  crs_flags u_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .fop(fop),
    .fop_mask(fop_mask),
    .upd_zero(upd_zero),
    .upd_carry(upd_carry),
    .zero_in(zero_in),
    .carry_in(carry_in),
    .super_enter(super_enter),
    .super_leave(super_leave),
    .flags_q(flags_q)
  );

  // ----------------------------------------
  // Interrupts pass only while global enable is set
  // ----------------------------------------
  assign irq_take = irq_pending & flags_q[`CRS_F_GIE];

  // ----------------------------------------
  // Read-only views; no external write path exists
  // ----------------------------------------
  assign program_counter_reg = pc_q;
  assign acc_reg = acc_q;
  assign index_reg = idx_q;
  assign stack_pointer_reg = sp_q;
  assign flags_reg = flags_q;
  assign pm_addr = pc_q;

endmodule

// ==== crs_mem_model.sv ====
`timescale 1ns/1ps
module crs_mem_model (
  // Program side
  input wire [15:0] pm_addr,
  output wire [7:0] pm_rdata,
  // Data side
  input wire [7:0] dm_addr,
  output wire [7:0] dm_rdata
);
  // Two separate address spaces, each answering at once
  assign pm_rdata = pm_addr[7:0] ^ 8'h5a;
  assign dm_rdata = dm_addr ^ 8'h3c;
endmodule

// ==== crs_assertions.sv ====
`timescale 1ns/1ps
module crs_chk (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Controls
  input wire [1:0] pc_op,
  input wire acc_we,
  input wire [7:0] acc_wdata,
  input wire [2:0] sp_op,
  input wire [7:0] dm_base,
  input wire dm_indexed,
  input wire super_enter,
  input wire super_leave,
  input wire irq_pending,
  // State
  input wire irq_take,
  input wire [15:0] program_counter_reg,
  input wire [7:0] acc_reg,
  input wire [7:0] index_reg,
  input wire [7:0] stack_pointer_reg,
  input wire [7:0] flags_reg,
  input wire [15:0] pm_addr,
  input wire [7:0] dm_addr_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_pc_reset: assert property (disable iff (1'b0)
    sys_rst |=> program_counter_reg == 16'h0000) else $error("pc not cleared");
  a_pc_step: assert property (
    pc_op == 2'h1 |=> program_counter_reg == $past(program_counter_reg) + 16'h0001)
    else $error("pc step wrong");
  a_pm_follow: assert property (pm_addr == program_counter_reg)
    else $error("pm address off pc");
  a_acc_load: assert property (acc_we |=> acc_reg == $past(acc_wdata))
    else $error("acc not loaded");
  a_idx_offset: assert property (
    dm_indexed |=> dm_addr_q == $past(dm_base) + $past(index_reg)) else $error("bad dm addr");
  a_sp_push: assert property (
    sp_op == 3'h1 |=> stack_pointer_reg == $past(stack_pointer_reg) + 8'h01)
    else $error("sp step wrong");
  a_super_keep: assert property (
    !super_enter && !super_leave |=> $stable(flags_reg[3])) else $error("super changed");
  a_super_set: assert property (super_enter |=> flags_reg[3])
    else $error("super not set");
  a_gie_gate: assert property (irq_take == (irq_pending & flags_reg[0]))
    else $error("irq gate wrong");
  a_rsvd_zero: assert property (flags_reg[7:5] == 3'h0)
    else $error("reserved flag set");
  c_push: cover property (sp_op == 3'h1);
  c_irq: cover property (irq_take);
  c_super: cover property (super_enter);
endmodule

bind crs_core_regs crs_chk crs_chk_i (.clk, .sys_rst, .pc_op, .acc_we, .acc_wdata, .sp_op,
  .dm_base, .dm_indexed, .super_enter, .super_leave, .irq_pending, .irq_take,
  .program_counter_reg, .acc_reg, .index_reg, .stack_pointer_reg, .flags_reg, .pm_addr,
  .dm_addr_q);

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  reg clk, sys_rst, acc_we, idx_we, dm_indexed, upd_zero, upd_carry, zero_in, carry_in;
  reg super_enter, super_leave, irq_pending;
  reg [1:0] pc_op, fop;
  reg [2:0] sp_op;
  reg [7:0] sp_load_val, dm_base, fop_mask, exp_sp;
  reg [15:0] pc_load_val;
  wire [7:0] acc_wdata, idx_wdata, acc_reg, index_reg, sp, flags, dm_addr_q;
  wire [15:0] pc, pm_addr;
  wire irq_take;
  integer num_errors, total_checks, i;
  crs_core_regs crs_core_regs_i (.clk(clk), .sys_rst(sys_rst), .pc_op(pc_op),
    .pc_load_val(pc_load_val), .acc_we(acc_we), .acc_wdata(acc_wdata), .idx_we(idx_we),
    .idx_wdata(idx_wdata), .sp_op(sp_op), .sp_load_val(sp_load_val), .dm_base(dm_base),
    .dm_indexed(dm_indexed), .fop(fop), .fop_mask(fop_mask), .upd_zero(upd_zero),
    .upd_carry(upd_carry), .zero_in(zero_in), .carry_in(carry_in),
    .super_enter(super_enter), .super_leave(super_leave), .irq_pending(irq_pending),
    .irq_take(irq_take), .program_counter_reg(pc), .acc_reg(acc_reg),
    .index_reg(index_reg), .stack_pointer_reg(sp), .flags_reg(flags), .pm_addr(pm_addr),
    .dm_addr_q(dm_addr_q));
  crs_mem_model crs_mem_model_i (.pm_addr(pm_addr), .pm_rdata(idx_wdata),
    .dm_addr(dm_addr_q), .dm_rdata(acc_wdata));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task chk(input [15:0] g, input [15:0] e);
    total_checks = total_checks + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One edge with the controls set, then all strobes back to idle
  task cyc;
    @(negedge clk);
    {pc_op, acc_we, idx_we, sp_op, dm_indexed, fop, upd_zero, upd_carry} = 0;
    {super_enter, super_leave} = 0;
  endtask
  task summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors = num_errors + 1;
    summarize;
  end
  initial begin
    num_errors = 0;
    total_checks = 0;
    sys_rst = 1;
    {zero_in, carry_in, irq_pending, sp_load_val, dm_base, fop_mask} = 27'h000_0000;
    pc_load_val = 16'h0000;
    cyc;
    repeat (2) @(negedge clk);
    sys_rst = 0;
    chk(pc, 16'h0000);
    chk({acc_reg, index_reg}, 16'h0000);
    chk({sp, flags}, 16'h0002);
    $display("reset test done");
    pc_op = 1;
    cyc;
    pc_op = 1;
    cyc;
    chk(pm_addr, 16'h0002);
    pc_op = 2;
    pc_load_val = 16'hffff;
    cyc;
    pc_op = 1;
    cyc;
    chk(pc, 16'h0000);
    $display("pc test done");
    sp_op = 7;
    sp_load_val = 8'h01;
    cyc;
    exp_sp = 8'h01;
    for (i = 6; i > 0; i = i - 1) begin
      sp_op = i;
      cyc;
      exp_sp = (i % 2) ? exp_sp + (i + 1) / 2 : exp_sp - i / 2;
      chk(sp, exp_sp);
    end
    $display("stack test done");
    idx_we = 1;
    cyc;
    chk(index_reg, 8'h5a);
    dm_base = 8'h05;
    dm_indexed = 1;
    acc_we = 1;
    cyc;
    chk(dm_addr_q, 8'h05 + 8'h5a);
    chk(acc_reg, 8'h00 ^ 8'h3c);
    acc_we = 1;
    cyc;
    chk(acc_reg, (8'h05 + 8'h5a) ^ 8'h3c);
    $display("data test done");
    irq_pending = 1;
    fop = 3;
    fop_mask = 8'hff;
    cyc;
    chk({flags, 7'h00, irq_take}, 16'h1701);
    fop = 2;
    fop_mask = 8'h00;
    super_enter = 1;
    cyc;
    chk({flags, 7'h00, irq_take}, 16'h0800);
    fop = 3;
    fop_mask = 8'h10;
    cyc;
    fop = 2;
    fop_mask = 8'h07;
    cyc;
    chk(flags, 8'h08);
    super_leave = 1;
    fop = 1;
    {upd_zero, upd_carry, zero_in, carry_in} = 4'hf;
    cyc;
    chk(flags, 8'h06);
    $display("flags test done");
    pc_op = 1;
    sp_op = 1;
    cyc;
    chk(pc, 16'h0001);
    sys_rst = 1;
    pc_op = 1;
    acc_we = 1;
    cyc;
    sys_rst = 0;
    chk(pc, 16'h0000);
    chk({sp, flags}, 16'h0002);
    chk(acc_reg, 8'h00);
    pc_op = 1;
    cyc;
    chk(pc, 16'h0001);
    $display("second reset test done");
    summarize;
  end
endmodule
